// ### design/uds_top.sv
// uart with async and dali (manchester) framing, axi4-lite registers
// assumes one clock, rx and cts pins asynchronous, rs-485 or dali phy
`timescale 1ns/1ns
`include "uds_cfg.svh"
module uds_top #(
  parameter uds_pkg::uds_rev_t REVISION = uds_pkg::REV_A4
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // axi4-lite write address
  input wire logic [`UDS_AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [`UDS_AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // line
  input wire logic RX_IN,
  output logic TX_OUT,
  output logic TX_DRIVER_ENABLE_OUT,
  // flow control
  input wire logic CTS_N,
  output logic RTS_N
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic idx_known(input logic [13:0] idx);
    idx_known = (idx == `UDS_IDX_CTRL) || (idx == `UDS_IDX_DIV) ||
      (idx == `UDS_IDX_STAT) || (idx == `UDS_IDX_TXD) ||
      (idx == `UDS_IDX_RXD) || (idx == `UDS_IDX_PPS_A) ||
      (idx == `UDS_IDX_PPS_B);
  endfunction : idx_known

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  function automatic logic [15:0] calc_div(input logic [19:0] cnt,
      input logic dali, input logic fast);
    logic [19:0] q;
    q = dali ? (cnt >> 3) : (fast ? (cnt >> 2) : (cnt >> 4));
    if (q == 20'h00000) q = 20'h00001;
    q = q - 20'h00001;
    calc_div = q[15:0];
  endfunction : calc_div

  // ****************************************
  // state and wiring
  // ****************************************
  uds_pkg::uds_ctrl_t ctrl;
  uds_pkg::uds_rx_state_t rx_state;
  uds_pkg::uds_tx_state_t tx_state;
  logic [15:0] baud_divisor;
  logic [7:0] pps_a;
  logic [7:0] pps_b;
  logic [7:0] tx_data;
  logic [7:0] tx_shift;
  logic [7:0] rx_data;
  logic [7:0] rx_shift;
  logic tx_pending, rx_full, overrun, frame_err, ab_done;
  logic [`UDS_AXI_AW-1:0] aw_addr;
  logic [`UDS_AXI_AW-1:0] ar_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] sync_q;
  logic rx_s, cts_n_s, rx_prev, tick, baud_restart;
  logic [3:0] rx_tk;
  logic [3:0] tx_tk;
  logic [2:0] rx_bit;
  logic [2:0] tx_bit;
  logic [19:0] meas_cnt;

  wire logic do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire logic do_read = !S_AXI_ARREADY && !S_AXI_RVALID;
  wire logic [13:0] w_idx = aw_addr[15:2];
  wire logic [13:0] r_idx = ar_addr[15:2];
  wire logic [31:0] wr_val = merge(32'h00000000, w_data, w_strb);
  wire logic [31:0] div_val = merge({16'h0000, baud_divisor}, w_data,
    w_strb);
  wire logic is_a1 = (REVISION == uds_pkg::REV_A1);

  // dali pins normal speed; fast select only reaches async framing
  wire logic fast = ctrl.baud_speed_select &&
    !ctrl.dali_mode;
  wire logic [3:0] tick_last =
    fast ? `UDS_TICK_LAST_FAST : `UDS_TICK_LAST_NORMAL;
  wire logic [3:0] sample_pt =
    ctrl.dali_mode ? `UDS_DALI_SAMPLE : (fast ? 4'h2 : `UDS_DALI_HALF);
  // a1 forces auto-baud on in dali; later revisions hold it off
  wire logic ab_active = ctrl.dali_mode ? is_a1
    : ctrl.autobaud_enable;
  // flow inputs only trusted with both pin selects at the good value
  wire logic pps_ok = (pps_a == `UDS_PPS_GOOD) &&
    (pps_b == `UDS_PPS_GOOD);
  wire logic cts_ok = !ctrl.flow_enable || (pps_ok && !cts_n_s);
  wire logic rx_fall = rx_prev && !rx_s;
  wire logic rx_tick = tick && (rx_state != uds_pkg::RX_IDLE) &&
    (rx_state != uds_pkg::RX_MEAS);
  wire logic rx_samp = rx_tick && (rx_tk == sample_pt);

  // ****************************************
  // submodules
  // ****************************************
  uds_sync #(.W(2)) u_sync (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .d({RX_IN, CTS_N}),
    .q(sync_q)
  );
  assign rx_s = sync_q[1];
  assign cts_n_s = sync_q[0];

  uds_baud_gen u_baud (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .divisor(baud_divisor),
    .restart(baud_restart),
    .tick(tick)
  );

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `UDS_RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= idx_known(w_idx) ? `UDS_RESP_OKAY : `UDS_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `UDS_RESP_OKAY;
      ar_addr <= '0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      ar_addr <= S_AXI_ARADDR;
    end else if (do_read) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= idx_known(r_idx) ? `UDS_RESP_OKAY : `UDS_RESP_SLVERR;
      unique case (r_idx)
        `UDS_IDX_CTRL: S_AXI_RDATA <= {27'h0000000, ctrl};
        `UDS_IDX_DIV: S_AXI_RDATA <= {16'h0000, baud_divisor};
        `UDS_IDX_STAT: S_AXI_RDATA <= {22'h000000, REVISION, 1'b0,
          ab_done, frame_err, ab_active, overrun, rx_full, tx_pending,
          tx_state != uds_pkg::TX_IDLE};
        `UDS_IDX_TXD: S_AXI_RDATA <= {24'h000000, tx_data};
        `UDS_IDX_RXD: S_AXI_RDATA <= {24'h000000, rx_data};
        `UDS_IDX_PPS_A: S_AXI_RDATA <= {24'h000000, pps_a};
        `UDS_IDX_PPS_B: S_AXI_RDATA <= {24'h000000, pps_b};
        default: S_AXI_RDATA <= 32'h00000000;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl <= `UDS_CTRL_RESET;
      pps_a <= `UDS_PPS_RESET;
      pps_b <= `UDS_PPS_RESET;
    end else begin
      if (do_write && w_idx == `UDS_IDX_CTRL && w_strb[0]) begin
        ctrl <= wr_val[4:0];
      end else if (rx_state == uds_pkg::RX_MEAS && rx_s &&
          !ctrl.dali_mode) begin
        ctrl.autobaud_enable <= 1'b0;
      end
      if (do_write && w_idx == `UDS_IDX_PPS_A && w_strb[0]) begin
        pps_a <= wr_val[7:0];
      end
      if (do_write && w_idx == `UDS_IDX_PPS_B && w_strb[0]) begin
        pps_b <= wr_val[7:0];
      end
    end
  end

  // divisor from software, or measured by auto-baud
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      baud_divisor <= `UDS_DIV_RESET;
    end else if (rx_state == uds_pkg::RX_MEAS && rx_s) begin
      baud_divisor <= calc_div(meas_cnt, ctrl.dali_mode, fast);
    end else if (do_write && w_idx == `UDS_IDX_DIV) begin
      baud_divisor <= div_val[15:0];
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tx_data <= 8'h00;
      tx_pending <= 1'b0;
    end else if (do_write && w_idx == `UDS_IDX_TXD && w_strb[0] &&
        !tx_pending) begin
      tx_data <= wr_val[7:0];
      tx_pending <= 1'b1;
    end else if (tx_state == uds_pkg::TX_IDLE && tick && cts_ok &&
        ctrl.enable) begin
      tx_pending <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tx_state <= uds_pkg::TX_IDLE;
      tx_shift <= 8'h00;
      tx_tk <= 4'h0;
      tx_bit <= 3'h0;
    end else if (tick) begin
      tx_tk <= (tx_tk == tick_last) ? 4'h0 : tx_tk + 4'h1;
      unique case (tx_state)
        uds_pkg::TX_IDLE: begin
          tx_tk <= 4'h0;
          if (tx_pending && cts_ok && ctrl.enable) begin
            tx_shift <= tx_data;
            tx_state <= uds_pkg::TX_START;
          end
        end
        uds_pkg::TX_START: begin
          if (tx_tk == tick_last) begin
            tx_bit <= 3'h0;
            tx_state <= uds_pkg::TX_DATA;
          end
        end
        uds_pkg::TX_DATA: begin
          if (tx_tk == tick_last) begin
            tx_shift <= ctrl.dali_mode ? {tx_shift[6:0], 1'b0}
              : {1'b0, tx_shift[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) begin
              tx_bit <= 3'h0;
              tx_state <= uds_pkg::TX_STOP;
            end
          end
        end
        uds_pkg::TX_STOP: begin
          if (tx_tk == tick_last) begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit + 3'h1 == (ctrl.dali_mode ? `UDS_STOP_DALI
                : `UDS_STOP_ASYNC)) begin
              tx_state <= uds_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // line level; dali encodes a one as low then high half bits
  logic cur_bit;
  always_comb begin
    unique case (tx_state)
      uds_pkg::TX_START: cur_bit = ctrl.dali_mode;
      uds_pkg::TX_DATA: cur_bit = ctrl.dali_mode ? tx_shift[7] : tx_shift[0];
      default: cur_bit = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      TX_OUT <= 1'b1;
      TX_DRIVER_ENABLE_OUT <= is_a1;
      RTS_N <= 1'b1;
    end else begin
      if (ctrl.dali_mode && (tx_state == uds_pkg::TX_START ||
          tx_state == uds_pkg::TX_DATA) && tx_tk < `UDS_DALI_HALF) begin
        TX_OUT <= !cur_bit;
      end else begin
        TX_OUT <= cur_bit;
      end
      TX_DRIVER_ENABLE_OUT <= (tx_state != uds_pkg::TX_IDLE) ^
        is_a1;
      RTS_N <= !(ctrl.flow_enable && ctrl.enable && !rx_full);
    end
  end

  // ****************************************
  // receive path
  // ****************************************
  assign baud_restart = (rx_state == uds_pkg::RX_IDLE && rx_fall &&
    ctrl.enable && !ab_active) || (rx_state == uds_pkg::RX_MEAS && rx_s);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rx_state <= uds_pkg::RX_IDLE;
      rx_prev <= 1'b1;
      rx_tk <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      meas_cnt <= 20'h00000;
    end else begin
      rx_prev <= rx_s;
      if (rx_tick) begin
        rx_tk <= (rx_tk == tick_last) ? 4'h0 : rx_tk + 4'h1;
      end
      unique case (rx_state)
        uds_pkg::RX_IDLE: begin
          rx_tk <= 4'h0;
          meas_cnt <= 20'h00000;
          if (rx_fall && ctrl.enable) begin
            rx_state <= ab_active ? uds_pkg::RX_MEAS
              : uds_pkg::RX_START;
          end
        end
        uds_pkg::RX_MEAS: begin
          // low phase: whole start bit, or half of it in dali
          meas_cnt <= meas_cnt + 20'h00001;
          if (rx_s) begin
            rx_tk <= ctrl.dali_mode ? `UDS_DALI_HALF : 4'h0;
            rx_bit <= 3'h0;
            rx_state <= ctrl.dali_mode ? uds_pkg::RX_START
              : uds_pkg::RX_DATA;
          end else if (meas_cnt == 20'hFFFFF) begin
            rx_state <= uds_pkg::RX_IDLE;
          end
        end
        uds_pkg::RX_START: begin
          if (rx_samp && rx_s != ctrl.dali_mode) begin
            rx_state <= uds_pkg::RX_IDLE;
          end else if (rx_tick && rx_tk == tick_last) begin
            rx_bit <= 3'h0;
            rx_state <= uds_pkg::RX_DATA;
          end
        end
        uds_pkg::RX_DATA: begin
          if (rx_samp) begin
            rx_shift <= ctrl.dali_mode ? {rx_shift[6:0], rx_s}
              : {rx_s, rx_shift[7:1]};
          end
          if (rx_tick && rx_tk == tick_last) begin
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= uds_pkg::RX_STOP;
            end
          end
        end
        uds_pkg::RX_STOP: begin
          if (rx_samp) begin
            rx_state <= uds_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // receive buffer and sticky flags; hardware set beats software clear
  wire logic rx_store = rx_state == uds_pkg::RX_STOP && rx_samp && rx_s;
  wire logic rx_bad = (rx_state == uds_pkg::RX_STOP && rx_samp && !rx_s) ||
    (rx_state == uds_pkg::RX_START && rx_samp && rx_s != ctrl.dali_mode);
  wire logic st_clr = do_write && w_idx == `UDS_IDX_STAT && w_strb[0];

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      ab_done <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_data <= rx_shift;
        rx_full <= 1'b1;
      end else if (do_read && r_idx == `UDS_IDX_RXD) begin
        rx_full <= 1'b0;
      end
      if (rx_store && rx_full) begin
        overrun <= 1'b1;
      end else if (st_clr && w_data[`UDS_ST_OVERRUN]) begin
        overrun <= 1'b0;
      end
      if (rx_bad) begin
        frame_err <= 1'b1;
      end else if (st_clr && w_data[`UDS_ST_FRM_ERR]) begin
        frame_err <= 1'b0;
      end
      if (rx_state == uds_pkg::RX_MEAS && rx_s) begin
        ab_done <= 1'b1;
      end else if (st_clr && w_data[`UDS_ST_AB_DONE]) begin
        ab_done <= 1'b0;
      end
    end
  end

endmodule : uds_top

// ### design/uds_cfg.svh
// register indices, reset values and bit timing of the dali/async uart
// assumes inclusion by bare name from design and sim files
`ifndef UDS_CFG_SVH
`define UDS_CFG_SVH

// ****************************************
// register indices, byte address = 4 x index
// ****************************************
`define UDS_IDX_CTRL 14'h0000
`define UDS_IDX_DIV 14'h0001
`define UDS_IDX_STAT 14'h0002
`define UDS_IDX_TXD 14'h0003
`define UDS_IDX_RXD 14'h0004
`define UDS_IDX_PPS_A 14'h3AE7
`define UDS_IDX_PPS_B 14'h3AEA
`define UDS_AXI_AW 16

// ****************************************
// reset values
// ****************************************
`define UDS_CTRL_RESET 5'h00
`define UDS_DIV_RESET 16'h0043
`define UDS_PPS_RESET 8'h00
`define UDS_PPS_GOOD 8'h18

// ****************************************
// status bit positions
// ****************************************
`define UDS_ST_TX_BUSY 0
`define UDS_ST_TX_PEND 1
`define UDS_ST_RX_FULL 2
`define UDS_ST_OVERRUN 3
`define UDS_ST_AB_ACT 4
`define UDS_ST_FRM_ERR 5
`define UDS_ST_AB_DONE 6

// ****************************************
// bit timing in baud ticks
// ****************************************
`define UDS_TICK_LAST_NORMAL 4'hF
`define UDS_TICK_LAST_FAST 4'h3
`define UDS_DALI_HALF 4'h8
`define UDS_DALI_SAMPLE 4'hC
`define UDS_STOP_ASYNC 3'h1
`define UDS_STOP_DALI 3'h2
`define UDS_RESP_OKAY 2'h0
`define UDS_RESP_SLVERR 2'h2

`endif

// ### design/uds_pkg.sv
// types shared by the dali/async uart
// assumes nothing beyond a systemverilog compiler
package uds_pkg;

  typedef enum logic [1:0] {
    REV_A1 = 2'h0,
    REV_A2 = 2'h1,
    REV_A4 = 2'h2
  } uds_rev_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_MEAS = 5'h02,
    RX_START = 5'h04,
    RX_DATA = 5'h08,
    RX_STOP = 5'h10
  } uds_rx_state_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } uds_tx_state_t;

  typedef struct packed {
    logic flow_enable;
    logic autobaud_enable;
    logic baud_speed_select;
    logic dali_mode;
    logic enable;
  } uds_ctrl_t;

endpackage : uds_pkg

// ### design/uds_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs come from outside the clock domain
`timescale 1ns/1ns
module uds_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= '1;
      q <= '1;
    end else begin
      stage <= d;
      q <= stage;
    end
  end

endmodule : uds_sync

// ### design/uds_baud_gen.sv
// baud tick generator: one tick every divisor+1 clocks
// assumes divisor and restart come from the same clock domain
`timescale 1ns/1ns
module uds_baud_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [15:0] divisor,
  input wire logic restart,
  // tick
  output logic tick
);

  logic [15:0] cnt;

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt >= divisor) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : uds_baud_gen

// ### sim/uds_top_assertions.sv
// checker for the uart register bus and line pins
// assumes binding into uds_top, one clock, synchronous reset
`timescale 1ns/1ns
module uds_chk #(
  parameter uds_pkg::uds_rev_t REVISION = uds_pkg::REV_A4
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // line and flow
  input wire logic TX_OUT,
  input wire logic TX_DRIVER_ENABLE_OUT,
  input wire logic RTS_N
);
  logic de_on;
  assign de_on = TX_DRIVER_ENABLE_OUT ^ (REVISION == uds_pkg::REV_A1);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ****************************************
  // checks
  // ****************************************
  chk_reset_idle: assert property (disable iff (1'b0)
    SYS_RST |=> S_AXI_AWREADY && S_AXI_ARREADY && !S_AXI_BVALID
    && !S_AXI_RVALID && RTS_N && TX_OUT)
    else $error("outputs wrong after reset");
  chk_b_after_aw: assert property (S_AXI_AWVALID && S_AXI_AWREADY
    && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_AWREADY && !S_AXI_WREADY
    ##1 S_AXI_BVALID) else $error("write answer late");
  chk_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write answer not released");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp moved");
  chk_r_after_ar: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> !S_AXI_ARREADY ##1 S_AXI_RVALID) else $error("read answer late");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata moved");
  chk_de_sending: assert property (
    !TX_OUT |-> de_on) else $error("driver enable off while sending");
  chk_de_char: assert property (
    $rose(de_on) |-> de_on [*8]) else $error("driver enable too short");
  chk_bit_min: assert property ($fell(TX_OUT) |-> !TX_OUT [*4])
    else $error("line low phase too short");
  cover property ($fell(TX_OUT));
  cover property (S_AXI_RVALID && S_AXI_RREADY);
  cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == 2'h2);
endmodule : uds_chk

bind uds_top uds_chk #(.REVISION(REVISION)) u_chk (.*);

// ### sim/uds_phy.sv
// line transceiver model: decodes uart frames, sends dali frames
// assumes line idle high, bit length in clocks set by BIT_CLKS
`timescale 1ns/1ns
module uds_phy #(
  parameter int BIT_CLKS = 64
) (
  // clock
  input wire logic clk,
  // line
  input wire logic line_in,
  input wire logic dali,
  output logic line_out,
  // decoded byte
  output logic [7:0] got,
  output logic got_stb
);
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // ****************************************
  // receive from uart
  // ****************************************
  always begin : rx_proc
    logic [7:0] v;
    @(negedge line_in);
    repeat (dali ? BIT_CLKS * 3 / 4 : BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      v = dali ? {v[6:0], line_in} : {line_in, v[7:1]};
    end
    repeat (BIT_CLKS) @(posedge clk);
    got <= v;
    got_stb <= 1'b1;
    @(posedge clk);
    got_stb <= 1'b0;
  end
  // dali frame, start bit one, msb first, two stop bits
  task automatic send(input logic [7:0] b);
    logic [8:0] f;
    f = {1'b1, b};
    for (int i = 8; i >= 0; i--) begin
      line_out <= ~f[i];
      repeat (BIT_CLKS / 2) @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CLKS / 2) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS * 2) @(posedge clk);
  endtask : send
endmodule : uds_phy

// ### sim/tb_uart_dali_baud_flow_quirks.sv
// self-checking bench for the dali/async uart
// assumes uds_top, uds_phy and the bound checker compiled before it
`timescale 1ns/1ns
`include "uds_cfg.svh"
module tb_uart_dali_baud_flow_quirks;
  localparam int BIT_CLKS = 64;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, CTS_N = 1'b1, phy_dali = 1'b0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [15:0] S_AXI_AWADDR = 16'h0000, S_AXI_ARADDR = 16'h0000;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, RX_IN, TX_OUT, TX_DRIVER_ENABLE_OUT, RTS_N, got_stb;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [7:0] got, b;
  logic [33:0] bus_q[$];
  logic [7:0] line_q[$];
  logic rts_q[$];
  int fails = 0;
  int n_checks = 0;
  always #4 REF_CLK = ~REF_CLK;
  uds_top u_dut (.*);
  uds_phy #(.BIT_CLKS(BIT_CLKS)) u_phy (
    .clk(REF_CLK),
    .line_in(TX_OUT),
    .dali(phy_dali),
    .line_out(RX_IN),
    .got(got),
    .got_stb(got_stb)
  );
  // ****************************************
  // compare and report
  // ****************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge REF_CLK) begin
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      check({S_AXI_BRESP, 32'h0}, bus_q.pop_front());
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      check({S_AXI_RRESP, S_AXI_RDATA}, bus_q.pop_front());
    end
    if (got_stb) check({26'h0, got}, {26'h0, line_q.pop_front()});
    if (rts_q.size() != 0) begin
      check({33'h0, RTS_N}, {33'h0, rts_q.pop_front()});
    end
  end
  // ****************************************
  // bus master and waits
  // ****************************************
  task automatic bus(input logic w, input logic [13:0] idx,
    input logic [31:0] d, input logic [1:0] resp);
    logic done = 1'b0;
    @(posedge REF_CLK);
    bus_q.push_back({resp, w ? 32'h0 : d});
    S_AXI_AWADDR <= {idx, 2'h0};
    S_AXI_ARADDR <= {idx, 2'h0};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    for (int n = 0; !done; n++) begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      done = (w && S_AXI_BVALID) || (!w && S_AXI_RVALID);
      if (n == 40) begin
        fails++;
        complete_run();
      end
    end
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
  endtask : bus
  task automatic wait_line;
    for (int n = 0; line_q.size() != 0; n++) begin
      @(posedge REF_CLK);
      if (n == 3000) begin
        fails++;
        complete_run();
      end
    end
    repeat (BIT_CLKS) @(posedge REF_CLK);
  endtask : wait_line
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(3));
    repeat (20) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    bus(0, `UDS_IDX_CTRL, 32'h0, 2'h0);
    bus(0, `UDS_IDX_DIV, 32'h43, 2'h0);
    bus(0, `UDS_IDX_PPS_A, 32'h0, 2'h0);
    bus(0, 14'h0010, 32'h0, 2'h2);
    bus(1, 14'h0020, 32'h5, 2'h2);
    bus(1, `UDS_IDX_DIV, 32'h3, 2'h0);
    CTS_N <= 1'b0;
    bus(1, `UDS_IDX_CTRL, 32'h11, 2'h0);
    b = 8'($urandom);
    bus(1, `UDS_IDX_TXD, {24'h0, b}, 2'h0);
    repeat (4 * BIT_CLKS) @(posedge REF_CLK);
    bus(0, `UDS_IDX_STAT, 32'h202, 2'h0);
    rts_q.push_back(1'b0);
    line_q.push_back(b);
    bus(1, `UDS_IDX_PPS_A, 32'h18, 2'h0);
    bus(1, `UDS_IDX_PPS_B, 32'h18, 2'h0);
    wait_line();
    phy_dali <= 1'b1;
    bus(1, `UDS_IDX_CTRL, 32'h0F, 2'h0);
    b = 8'($urandom);
    line_q.push_back(b);
    bus(1, `UDS_IDX_TXD, {24'h0, b}, 2'h0);
    rts_q.push_back(1'b1);
    wait_line();
    b = 8'($urandom);
    u_phy.send(b);
    bus(0, `UDS_IDX_RXD, {24'h0, b}, 2'h0);
    bus(0, `UDS_IDX_STAT, 32'h200, 2'h0);
    bus(0, `UDS_IDX_DIV, 32'h3, 2'h0);
    complete_run();
  end
endmodule : tb_uart_dali_baud_flow_quirks
